// File: core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Core and supply stand-in
module core_model (
	input  wire logic clk_sys_i,
	input  wire logic core_rst_i,
	output logic      supply_good_o,
	output logic      reset_request_o,
	output int        boots_o
);
	logic rst_q;
	initial begin
		supply_good_o = 1'b1;
		reset_request_o = 1'b0;
		boots_o = 0;
		rst_q = 1'b0;
	end
	// Each release of internal reset starts a fresh boot fetch
	always @(posedge clk_sys_i) begin
		rst_q <= core_rst_i;
		if (rst_q && !core_rst_i) boots_o <= boots_o + 1;
	end
	task automatic request();
		@(posedge clk_sys_i);
		reset_request_o <= 1'b1;
		@(posedge clk_sys_i);
		reset_request_o <= 1'b0;
	endtask : request
	task automatic sag(input int n);
		@(posedge clk_sys_i);
		supply_good_o <= 1'b0;
		repeat (n) @(posedge clk_sys_i);
		supply_good_o <= 1'b1;
	endtask : sag
endmodule : core_model
`default_nettype wire

// File: reset_and_clock_source_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "rst_clk_cfg.svh"
// Behaviour
// [R1] Brown-out reset disabled until software enables
// [R2] Brown-out raises interrupt or reset
// [R3] Brown-out resets only when select bit set
// [R4] Reset held while supply not good
// [R5] Cause register records brown-out reset
// [R6] Three peripheral reset registers, held while set
// [R7] Reset bits map like clock-gating bits
// [R8] Peripheral reset hits all its clock domains
// [R9] Core request resets whole system
// [R10] Watchdog interrupt first, reset second time-out
// [R11] Reload counter after first time-out
// [R12] Reset only if interrupt uncleared, enabled
// [R13] Regulator voltage-adjust field is writable
// [R14] Internal oscillator selected after reset
// [R15] Software settles main oscillator before switching
// [R16] Mux offers oscillators, PLL, internal div four
// [R17] Software keeps PLL reference in range
// [R18] Skip set: source field picks clock
// [R19] PLL used when skip clear, source main
// [R20] Extended source 0x7 selects real-time oscillator
// [R21] Main oscillator may power down on 30 kHz
// [R22] Cause bits sticky; pin reset clears others
// [R23] Internal reset pulses last fixed cycles
module reset_and_clock_source_ctrl
	import rst_clk_pkg::*;
(
	input  wire logic          clk_sys_i,
	input  wire logic          reset_n_i,
	input  wire logic          clk_en_i,
	input  wire logic          por_i,
	input  wire logic          ext_reset_n_i,
	input  wire logic          supply_good_i,
	input  wire logic          system_reset_request_i,
	input  wire reg_req_type   reg_req_i,
	output logic [31:0]        reg_rdata_o,
	output reset_out_type      reset_o,
	output logic               brownout_irq_o,
	output logic               watchdog_irq_o,
	output clk_sel_type        clk_sel_o,
	output logic               main_osc_pd_o,
	output logic [5:0]         regulator_voltage_adjust_o
);

	state_type q;
	state_type d;

	// ======================================================
	// Helpers
	// ======================================================
	function automatic logic [31:0] clear_on_write(input logic [31:0] cur,
		input logic hit, input logic [31:0] wv);
		clear_on_write = hit ? (cur & ~wv) : cur;
	endfunction : clear_on_write

	function automatic clk_sel_type decode_clock(input logic [15:0] cfg);
		clk_sel_type s;
		s = CLK_INT;
		if (cfg[`CLK_EXT_USE_BIT] && cfg[`CLK_SKIP_BIT] &&
			cfg[`CLK_SRC_EXT_MSB:`CLK_SRC_EXT_LSB] == `SRC_EXT_RTC) begin
			s = CLK_EXT_RTC; // [R20]
		end else begin
			case (cfg[`CLK_SRC_MSB:`CLK_SRC_LSB]) // [R18] [R16]
				`SRC_MAIN:     s = cfg[`CLK_SKIP_BIT] ? CLK_MAIN : CLK_PLL; // [R19]
				`SRC_INT:      s = CLK_INT;
				`SRC_INT_DIV4: s = CLK_INT_DIV4;
				`SRC_LOW30K:   s = CLK_LOW30K;
				default:       s = CLK_INT;
			endcase
		end
		decode_clock = s;
	endfunction : decode_clock

	// ======================================================
	// Next state
	// ======================================================
	logic pin_reset;
	logic bo_sync_ok;
	logic wd_zero;
	logic wd_fire;
	logic bo_fire;
	logic wr_hit_wctl;
	logic [4:0] cause_set;

	always_comb begin
		d = q;
		pin_reset   = por_i || !ext_reset_n_i;
		bo_sync_ok  = q.bo_sync[1];
		wd_zero     = (q.wd_count == 32'h0000_0000);
		wd_fire     = 1'b0;
		bo_fire     = 1'b0;
		cause_set   = 5'h00;
		wr_hit_wctl = reg_req_i.wr && reg_req_i.addr == `ADDR_WDOG_CTRL;
		d.rdata     = 32'h0000_0000;

		// Supply-good passes two flops; the pin is asynchronous
		d.bo_sync = {q.bo_sync[0], supply_good_i};

		// Brown-out: interrupt or reset by the select bit
		if (!bo_sync_ok) begin
			if (q.bo_ctrl[`BO_RESET_SEL_BIT]) begin // [R3] [R1]
				bo_fire = 1'b1; // [R2]
			end else if (q.bo_ctrl[`BO_INT_EN_BIT]) begin
				d.bo_int = 1'b1; // [R2]
			end
		end

		// Watchdog down-counter
		if (q.wd_ctrl[`WD_EN_BIT]) begin
			if (wd_zero) begin
				d.wd_count = q.wd_load; // [R11]
				case (q.wd_state)
					WD_IDLE: begin
						d.wd_state = WD_FIRST;
						d.wd_int   = 1'b1; // [R10]
					end
					WD_FIRST: begin
						if (q.wd_int && q.wd_ctrl[`WD_RESEN_BIT]) begin
							wd_fire = 1'b1; // [R12]
						end
					end
					default: d.wd_state = WD_IDLE;
				endcase
			end else begin
				d.wd_count = q.wd_count - 32'h0000_0001;
			end
		end

		// Register writes
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				`ADDR_BROWNOUT_CTRL: d.bo_ctrl  = reg_req_i.wdata[1:0]; // [R1]
				`ADDR_SW_RESET0:     d.sw_rst0  = reg_req_i.wdata; // [R6] [R7]
				`ADDR_SW_RESET1:     d.sw_rst1  = reg_req_i.wdata; // [R6]
				`ADDR_SW_RESET2:     d.sw_rst2  = reg_req_i.wdata; // [R6]
				`ADDR_WDOG_LOAD: begin
					d.wd_load  = reg_req_i.wdata;
					d.wd_count = reg_req_i.wdata;
				end
				`ADDR_WDOG_CTRL:     d.wd_ctrl  = reg_req_i.wdata[1:0];
				`ADDR_REG_CTRL:      d.regulator_voltage_adjust     = reg_req_i.wdata[5:0]; // [R13]
				`ADDR_CLOCK_CONFIG:  d.clk_cfg  = reg_req_i.wdata[15:0];
				`ADDR_RESET_CAUSE:   d.cause    = 5'(clear_on_write(
					{27'h0, q.cause}, 1'b1, reg_req_i.wdata));
				default: ;
			endcase
			if (reg_req_i.addr == `ADDR_BROWNOUT_CTRL && reg_req_i.wdata[2]) begin
				d.bo_int = 1'b0;
			end
		end
		// Interrupt clear, but a new time-out in the same cycle wins
		if (wr_hit_wctl && reg_req_i.wdata[`WD_INTCLR_BIT] &&
			!(wd_zero && q.wd_state == WD_IDLE && q.wd_ctrl[`WD_EN_BIT])) begin
			d.wd_int   = 1'b0;
			d.wd_state = WD_IDLE;
		end

		// Reads: data stand in the next cycle
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				`ADDR_BROWNOUT_CTRL: d.rdata = {29'h0, q.bo_int, q.bo_ctrl};
				`ADDR_RESET_CAUSE:   d.rdata = {27'h0, q.cause}; // [R5]
				`ADDR_SW_RESET0:     d.rdata = q.sw_rst0;
				`ADDR_SW_RESET1:     d.rdata = q.sw_rst1;
				`ADDR_SW_RESET2:     d.rdata = q.sw_rst2;
				`ADDR_WDOG_LOAD:     d.rdata = q.wd_load;
				`ADDR_WDOG_CTRL:     d.rdata = {29'h0, q.wd_int, q.wd_ctrl};
				`ADDR_WDOG_VALUE:    d.rdata = q.wd_count;
				`ADDR_REG_CTRL:      d.rdata = {26'h0, q.regulator_voltage_adjust};
				`ADDR_CLOCK_CONFIG:  d.rdata = {16'h0, q.clk_cfg};
				default:             d.rdata = 32'h0000_0000;
			endcase
		end

		// System reset sources: cause bits set, pulse starts
		if (bo_fire) begin
			cause_set[`CAUSE_BO_BIT] = 1'b1; // [R5]
			// Select bit is cleared by the reset itself, so remember the source
			d.bo_hold = 1'b1; // [R4]
		end
		if (system_reset_request_i) begin
			cause_set[`CAUSE_SW_BIT] = 1'b1; // [R9]
		end
		if (wd_fire) begin
			cause_set[`CAUSE_WD_BIT] = 1'b1;
		end
		if (cause_set != 5'h00) begin
			d.cause     = q.cause | cause_set; // [R22]
			d.rst_act   = 1'b1;
			d.pulse_cnt = 8'(`RESET_PULSE_CYC); // [R23]
		end else if (q.rst_act) begin
			if (q.pulse_cnt != 8'h00) begin
				d.pulse_cnt = q.pulse_cnt - 8'h01; // [R23]
			end else if (bo_sync_ok || !q.bo_hold) begin
				d.rst_act = 1'b0; // [R4]
				d.bo_hold = 1'b0;
			end
		end

		// Internal reset clears control except the regulator adjust field, and keeps sticky cause bits
		if (q.rst_act) begin
			d.bo_ctrl  = 2'b00; // [R1]
			d.sw_rst0  = 32'h0000_0000;
			d.sw_rst1  = 32'h0000_0000;
			d.sw_rst2  = 32'h0000_0000;
			d.wd_ctrl  = 2'b00;
			d.wd_int   = 1'b0;
			d.wd_state = WD_IDLE;
			d.wd_load  = `RST_WDOG_LOAD;
			d.wd_count = `RST_WDOG_LOAD;
			d.clk_cfg  = `RST_CLOCK_CONFIG; // [R14]
			d.bo_int   = 1'b0;
		end
		// Pin or power-on reset leaves only its own cause bit
		if (pin_reset) begin
			d.cause = 5'h00; // [R22]
			d.cause[`CAUSE_POR_BIT] = por_i;
			d.cause[`CAUSE_EXT_BIT] = !por_i;
		end
	end

	// ======================================================
	// State register
	// ======================================================
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			q          <= '0;
			q.clk_cfg  <= `RST_CLOCK_CONFIG; // [R14]
			q.wd_load  <= `RST_WDOG_LOAD;
			q.wd_count <= `RST_WDOG_LOAD;
			q.regulator_voltage_adjust     <= `RST_REGULATOR_VOLTAGE_ADJUST;
			q.cause[`CAUSE_POR_BIT] <= 1'b1;
			q.bo_sync  <= 2'b11;
		end else if (clk_en_i) begin
			q <= d;
		end
	end

	// ======================================================
	// Outputs
	// ======================================================
	// Cause register holds through internal resets, so core sees it after restart
	always_comb begin
		reset_o.core_rst       = q.rst_act; // [R9]
		reset_o.periph_rst     = q.rst_act;
		// One bit drives every clock-domain reset of its unit
		reset_o.periph_sw_rst0 = q.sw_rst0 | {32{q.rst_act}}; // [R8]
		reset_o.periph_sw_rst1 = q.sw_rst1 | {32{q.rst_act}}; // [R8]
		reset_o.periph_sw_rst2 = q.sw_rst2 | {32{q.rst_act}}; // [R8]
	end

	assign reg_rdata_o                = q.rdata;
	assign brownout_irq_o             = q.bo_int;
	assign watchdog_irq_o             = q.wd_int;
	assign clk_sel_o                  = decode_clock(q.clk_cfg);
	assign main_osc_pd_o              = q.clk_cfg[`CLK_MAIN_OSC_OFF_BIT] &&
		clk_sel_o != CLK_MAIN && clk_sel_o != CLK_PLL; // [R21]
	assign regulator_voltage_adjust_o = q.regulator_voltage_adjust;

	// ======================================================
	// Checks
	// ======================================================
	sequence bo_low_s;
		!q.bo_sync[1] && q.bo_ctrl[`BO_RESET_SEL_BIT];
	endsequence

	bo_reset_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R3]
		(clk_en_i && !pin_reset) and bo_low_s |=> q.rst_act)
		else $error("brown-out with select did not reset");
	bo_off_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R1]
		q.rst_act && clk_en_i |=> !q.bo_ctrl[`BO_RESET_SEL_BIT])
		else $error("brown-out select survived reset");
	sysreq_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R9]
		clk_en_i && system_reset_request_i |=> reset_o.core_rst && reset_o.periph_rst)
		else $error("core request did not reset system");
	pulse_len_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R23]
		clk_en_i && $rose(q.rst_act) |-> q.pulse_cnt == 8'(`RESET_PULSE_CYC))
		else $error("reset pulse length wrong");
	wd_reload_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R11]
		clk_en_i && q.wd_ctrl[0] && wd_zero && !reg_req_i.wr && !q.rst_act
		|=> q.wd_count == $past(q.wd_load))
		else $error("watchdog did not reload");
	wd_second_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R12]
		clk_en_i && wd_fire |=> q.rst_act && q.cause[`CAUSE_WD_BIT])
		else $error("second time-out did not reset");
	cause_bo_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R5]
		clk_en_i && bo_fire && !pin_reset |=> q.cause[`CAUSE_BO_BIT])
		else $error("brown-out cause not recorded");
	pin_cause_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R22]
		clk_en_i && por_i |=> q.cause == 5'h02)
		else $error("power-on did not clear other causes");
	swrst_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R6]
		(reset_o.periph_sw_rst0 & q.sw_rst0) == q.sw_rst0)
		else $error("peripheral reset not held");
endmodule : reset_and_clock_source_ctrl
`default_nettype wire

// File: rst_clk_cfg.svh
`ifndef RST_CLK_CFG_SVH
`define RST_CLK_CFG_SVH

// Register map, word addresses on the plain register port
`define ADDR_BROWNOUT_CTRL   4'h0
`define ADDR_RESET_CAUSE     4'h1
`define ADDR_SW_RESET0       4'h2
`define ADDR_SW_RESET1       4'h3
`define ADDR_SW_RESET2       4'h4
`define ADDR_WDOG_LOAD       4'h5
`define ADDR_WDOG_CTRL       4'h6
`define ADDR_WDOG_VALUE      4'h7
`define ADDR_REG_CTRL        4'h8
`define ADDR_CLOCK_CONFIG    4'h9

// Field positions
`define BO_INT_EN_BIT        0
`define BO_RESET_SEL_BIT     1
`define CAUSE_EXT_BIT        0
`define CAUSE_POR_BIT        1
`define CAUSE_BO_BIT         2
`define CAUSE_SW_BIT         3
`define CAUSE_WD_BIT         4
`define WD_EN_BIT            0
`define WD_RESEN_BIT         1
`define WD_INTCLR_BIT        2
`define CLK_SKIP_BIT         11
`define CLK_SRC_LSB          4
`define CLK_SRC_MSB          5
`define CLK_SRC_EXT_LSB      12
`define CLK_SRC_EXT_MSB      14
`define CLK_EXT_USE_BIT      15
`define CLK_MAIN_OSC_OFF_BIT     0

// Reset values
`define RST_CLOCK_CONFIG     16'h0811
`define RST_WDOG_LOAD        32'hffff_ffff
`define RST_REGULATOR_VOLTAGE_ADJUST             6'h00

// Oscillator source encodings
`define SRC_MAIN             2'h0
`define SRC_INT              2'h1
`define SRC_INT_DIV4         2'h2
`define SRC_LOW30K           2'h3
`define SRC_EXT_RTC          3'h7

// Internal reset pulse length
`define RESET_PULSE_NS       160
`define RESET_PULSE_CYC      (`RESET_PULSE_NS / 10)

`endif

// File: rst_clk_pkg.sv
package rst_clk_pkg;
	typedef enum logic [2:0] {
		CLK_MAIN, CLK_PLL, CLK_INT, CLK_INT_DIV4, CLK_LOW30K, CLK_EXT_RTC
	} clk_sel_type;

	typedef enum logic [1:0] {WD_IDLE, WD_FIRST, WD_SECOND} wd_state_type;

	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_type;

	typedef struct packed {
		logic       core_rst;
		logic       periph_rst;
		logic [31:0] periph_sw_rst0;
		logic [31:0] periph_sw_rst1;
		logic [31:0] periph_sw_rst2;
	} reset_out_type;

	typedef struct packed {
		logic [1:0]   bo_ctrl;
		logic [4:0]   cause;
		logic [31:0]  sw_rst0;
		logic [31:0]  sw_rst1;
		logic [31:0]  sw_rst2;
		logic [31:0]  wd_load;
		logic [31:0]  wd_count;
		logic [1:0]   wd_ctrl;
		wd_state_type wd_state;
		logic         wd_int;
		logic [5:0]   regulator_voltage_adjust;
		logic [15:0]  clk_cfg;
		logic [7:0]   pulse_cnt;
		logic         rst_act;
		logic         bo_hold;
		logic         bo_int;
		logic [31:0]  rdata;
		logic         por_done;
		logic [1:0]   bo_sync;
	} state_type;
endpackage : rst_clk_pkg

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rst_clk_cfg.svh"
module tb_top
	import rst_clk_pkg::*;
;
	logic          clk = 1'b0;
	logic          reset_n = 1'b0;
	logic          ext_n = 1'b1;
	logic          por = 1'b0;
	reg_req_type   req = '0;
	logic [31:0]   rdata;
	reset_out_type rst_o;
	logic          bo_irq, wd_irq, pd, sg, rq, rd_d = 1'b0;
	clk_sel_type   sel;
	logic [5:0]    regulator_voltage_adjust;
	int            boots, mismatches = 0, tests_run = 0;
	logic [31:0]   exp_q[$];
	clk_sel_type   tab[4] = '{CLK_MAIN, CLK_INT, CLK_INT_DIV4, CLK_LOW30K};

	always #5 clk = ~clk;

	reset_and_clock_source_ctrl reset_and_clock_source_ctrl_i (
		.clk_sys_i(clk), .reset_n_i(reset_n), .clk_en_i(1'b1), .por_i(por),
		.ext_reset_n_i(ext_n), .supply_good_i(sg), .system_reset_request_i(rq),
		.reg_req_i(req), .reg_rdata_o(rdata), .reset_o(rst_o), .brownout_irq_o(bo_irq),
		.watchdog_irq_o(wd_irq), .clk_sel_o(sel), .main_osc_pd_o(pd),
		.regulator_voltage_adjust_o(regulator_voltage_adjust));
	core_model core_model_i (.clk_sys_i(clk), .core_rst_i(rst_o.core_rst),
		.supply_good_o(sg), .reset_request_o(rq), .boots_o(boots));

	// ==========
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("compares=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
	endtask : rd
	// Bounded wait on core reset (w=0) or watchdog interrupt (w=1)
	task automatic wait_sig(input int w, input logic lvl, input int lim, output int n);
		n = 0;
		while ((w == 0 ? rst_o.core_rst : wd_irq) !== lvl) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				mismatches++;
				end_sim();
			end
		end
	endtask : wait_sig

	// Read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_d) chk(rdata, exp_q.pop_front());
		rd_d <= req.rd;
	end

	initial begin
		repeat (50000) @(posedge clk);
		mismatches++;
		end_sim();
	end

	// ==========
	// Main sequence
	initial begin
		int n, b0, i;
		logic [31:0] v, d[3];
		v = $urandom(24833);
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		rd(`ADDR_RESET_CAUSE, 32'h02);
		rd(`ADDR_CLOCK_CONFIG, `RST_CLOCK_CONFIG);
		rd(`ADDR_BROWNOUT_CTRL, 32'h0);
		@(negedge clk);
		chk(32'(sel), 32'(CLK_INT));
		$display("test reset done");
		wr(`ADDR_CLOCK_CONFIG, 32'h0800);
		for (i = 0; i < 4; i++) begin
			wr(`ADDR_CLOCK_CONFIG, 32'h0800 | (i << 4));
			@(negedge clk);
			chk(32'(sel), 32'(tab[i]));
		end
		// Main oscillator serves as the in-range PLL reference
		wr(`ADDR_CLOCK_CONFIG, 32'h0000);
		@(negedge clk);
		chk(32'(sel), 32'(CLK_PLL));
		wr(`ADDR_CLOCK_CONFIG, 32'hf800);
		@(negedge clk);
		chk(32'(sel), 32'(CLK_EXT_RTC));
		wr(`ADDR_CLOCK_CONFIG, 32'h0831);
		@(negedge clk);
		chk(32'(pd), 32'h1);
		v = $urandom & 32'h3f;
		wr(`ADDR_REG_CTRL, v);
		rd(`ADDR_REG_CTRL, v);
		chk(32'(regulator_voltage_adjust), v);
		$display("test clock done");
		for (i = 0; i < 3; i++) begin
			d[i] = $urandom;
			wr(4'(`ADDR_SW_RESET0 + i), d[i]);
		end
		@(negedge clk);
		chk(rst_o.periph_sw_rst0, d[0]);
		chk(rst_o.periph_sw_rst1, d[1]);
		chk(rst_o.periph_sw_rst2, d[2]);
		chk(32'(rst_o.core_rst), 32'h0);
		rd(`ADDR_SW_RESET2, d[2]);
		for (i = 0; i < 3; i++) wr(4'(`ADDR_SW_RESET0 + i), 32'h0);
		@(negedge clk);
		chk(rst_o.periph_sw_rst1, 32'h0);
		$display("test periph done");
		wr(`ADDR_BROWNOUT_CTRL, 32'h1);
		core_model_i.sag(30);
		@(negedge clk);
		chk(32'(rst_o.core_rst), 32'h0);
		chk(32'(bo_irq), 32'h1);
		repeat (4) @(posedge clk);
		wr(`ADDR_BROWNOUT_CTRL, 32'h4);
		@(negedge clk);
		chk(32'(bo_irq), 32'h0);
		wr(`ADDR_BROWNOUT_CTRL, 32'h2);
		fork
			core_model_i.sag(40);
		join_none
		wait_sig(0, 1'b1, 10, n);
		wait_sig(0, 1'b0, 90, n);
		chk(32'(n >= 35), 32'h1);
		rd(`ADDR_RESET_CAUSE, 32'h06);
		$display("test brownout done");
		b0 = boots;
		core_model_i.request();
		@(negedge clk);
		wait_sig(0, 1'b1, 5, n);
		chk(n, 0);
		chk({rst_o.periph_rst, rst_o.periph_sw_rst0[0]}, 2'b11);
		chk(rst_o.periph_sw_rst1 & rst_o.periph_sw_rst2, 32'hffff_ffff);
		wait_sig(0, 1'b0, 40, n);
		chk(32'(n >= 15 && n <= 18), 32'h1);
		@(negedge clk);
		chk(boots, b0 + 1);
		rd(`ADDR_RESET_CAUSE, 32'h0e);
		$display("test request done");
		@(posedge clk);
		ext_n <= 1'b0;
		repeat (3) @(posedge clk);
		ext_n <= 1'b1;
		wait_sig(0, 1'b0, 40, n);
		rd(`ADDR_RESET_CAUSE, 32'h01);
		$display("test pin done");
		wr(`ADDR_WDOG_LOAD, 32'd20);
		wr(`ADDR_WDOG_CTRL, 32'h1);
		b0 = boots;
		wait_sig(1, 1'b1, 40, n);
		chk(32'(rst_o.core_rst), 32'h0);
		repeat (60) @(negedge clk);
		chk(boots, b0);
		wr(`ADDR_WDOG_CTRL, 32'h7);
		wait_sig(1, 1'b1, 30, n);
		wait_sig(0, 1'b1, 30, n);
		chk(32'(n >= 18 && n <= 23), 32'h1);
		wait_sig(0, 1'b0, 40, n);
		rd(`ADDR_RESET_CAUSE, 32'h11);
		@(posedge clk);
		por <= 1'b1;
		@(posedge clk);
		por <= 1'b0;
		rd(`ADDR_RESET_CAUSE, 32'h02);
		repeat (2) @(posedge clk);
		$display("test watchdog done");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
